// ===== rtl/dcr_pkg.sv
package dcr_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int          DCR_ARRAY_BITS  = 4608;
    localparam int          DCR_WORD_BITS   = 9;
    localparam int          DCR_WORDS       = DCR_ARRAY_BITS / DCR_WORD_BITS;
    localparam int          DCR_ADDR_BITS   = 12;
    localparam int          DCR_DATA_BITS   = 18;
    // FIFO pointers count in bit units of the low eight bits per word
    localparam int          DCR_PTR_BITS    = 13;
    localparam logic [12:0] DCR_UNITS_TOTAL = 13'h1000;

    // ------------------------------------------------------------
    // Reset values and default thresholds
    // ------------------------------------------------------------
    localparam logic [12:0] DCR_PTR_RST     = 13'h0000;
    localparam logic [17:0] DCR_DATA_RST    = 18'h0_0000;
    localparam logic [12:0] DCR_ALMOST_FULL_FLAG_DEF   = 13'h0E00;
    localparam logic [12:0] DCR_ALMOST_EMPTY_FLAG_DEF  = 13'h0200;
    localparam int          DCR_BUF_DEPTH   = 4;

    // Widths 1, 2, 4, 9 and 18 bits; the first four match aspect codes
    typedef enum logic [2:0] {
        DCR_W1, DCR_W2, DCR_W4, DCR_W9, DCR_W18
    } dcr_width_t;

    typedef struct packed {
        logic [17:0] a_stage;
        logic [17:0] a_out;
        logic        a_pend;
        logic [17:0] b_stage;
        logic [17:0] b_out;
        logic        b_pend;
        logic [12:0] wptr;
        logic [12:0] rptr;
    } dcr_state_t;

    // Bit units covered by one access of the given width
    function automatic logic [4:0] dcr_units(dcr_width_t w);
        return 5'(5'd1 << w);
    endfunction : dcr_units

    // Unused codes fall back to nine bits
    function automatic dcr_width_t dcr_decode(logic [2:0] c);
        return (c > 3'h4) ? DCR_W9 : dcr_width_t'(c);
    endfunction : dcr_decode

    // Address in words of width w to bit-unit position
    function automatic logic [11:0] dcr_pos(logic [11:0] addr,
                                            dcr_width_t w);
        logic [15:0] p;
        p = 16'(addr) << w;
        return p[11:0];
    endfunction : dcr_pos

endpackage : dcr_pkg

// ===== rtl/dcr_stream_buf.sv
`timescale 1ns/1ps
module dcr_stream_buf #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } dcr_buf_state_t;

    dcr_buf_state_t st;
    dcr_buf_state_t next_st;
    logic           push;
    logic           pop;

    assign in_ready  = (st.cnt != (PW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.slot[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.slot[st.wp] = in_data;
            next_st.wp = (st.wp == PW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == PW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_buf_no_overrun: assert property (@(posedge clk)
        disable iff (!rst_n)
        st.cnt == (PW+1)'(DEPTH) |=> st.cnt <= (PW+1)'(DEPTH))
        else $error("buffer accepts while full");

endmodule : dcr_stream_buf

// ===== rtl/dcr_block.sv
// How it works
// - One storage array of 4,608 bits serves every organization.
// - Reads and writes happen only on clock edges.
// - Read and write timing independent; rated up to 250 MHz.
// - Dual-port organizations 4kx1, 2kx2, 1kx4, 512x9 on both ports.
// - Two-port 512x9 or 256x18; port A writes, port B reads.
// - Writes synchronous; each read path pipelined or not.
// - Built-in FIFO controller makes addresses and four status flags.
// - RAM mode takes user addresses; FIFO pointers are ignored.
// - FIFO mode muxes controller addresses onto the array.
// - Same-address accesses from both ports are accepted.
// - Write and read widths chosen independently for bus conversion.
// - With 1, 2 or 4 bit widths the ninth bit is unused.
// - Nine-bit writes, four-bit reads: only two nibbles readable.
// - Four-bit writes, nine-bit reads: ninth bit undefined.
// - Narrow words map little-endian into wider words.
// - Output register off: data next edge; on: one cycle later.
// - Write-not-read low writes, high reads.
// - Deselected port holds its output once its last registered read has landed.
`timescale 1ns/1ps
module dcr_block
    import dcr_pkg::*;
#(
    parameter logic [12:0] ALMOST_FULL_FLAG_LEVEL  = dcr_pkg::DCR_ALMOST_FULL_FLAG_DEF,
    parameter logic [12:0] ALMOST_EMPTY_FLAG_LEVEL = dcr_pkg::DCR_ALMOST_EMPTY_FLAG_DEF,
    parameter int          BUF_DEPTH    = dcr_pkg::DCR_BUF_DEPTH
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        FIFO_MODE,
    input  wire logic        TWO_PORT_MODE,
    input  wire logic [1:0]  PORT_A_ASPECT_SELECT,
    input  wire logic [1:0]  PORT_B_ASPECT_SELECT,
    input  wire logic [2:0]  WRITE_WIDTH_SELECT,
    input  wire logic [2:0]  READ_WIDTH_SELECT,
    input  wire logic        PORT_A_OUTPUT_REGISTER_SELECT,
    input  wire logic        PORT_B_OUTPUT_REGISTER_SELECT,
    input  wire logic        PORT_A_SELECT_N,
    input  wire logic        PORT_B_SELECT_N,
    input  wire logic        PORT_A_WRITE_NOT_READ,
    input  wire logic        PORT_B_WRITE_NOT_READ,
    input  wire logic [11:0] PORT_A_ADDR,
    input  wire logic [11:0] PORT_B_ADDR,
    input  wire logic [17:0] PORT_A_WDATA,
    input  wire logic [17:0] PORT_B_WDATA,
    output logic      [17:0] PORT_A_RDATA,
    output logic      [17:0] PORT_B_RDATA,
    input  wire logic        FIFO_WR_VALID,
    output logic             FIFO_WR_READY,
    output logic             FIFO_RD_VALID,
    input  wire logic        FIFO_RD_READY,
    output logic      [17:0] FIFO_RD_DATA,
    output logic             FULL,
    output logic             EMPTY,
    output logic             ALMOST_FULL_FLAG,
    output logic             ALMOST_EMPTY_FLAG
);
    import dcr_pkg::*;

    // ------------------------------------------------------------
    // Storage and state
    // ------------------------------------------------------------
    // Contents survive reset on purpose; only control state clears
    logic [8:0]  mem [DCR_WORDS];
    dcr_state_t  st;
    dcr_state_t  next_st;

    dcr_width_t  wa;
    dcr_width_t  wb;
    logic [11:0] pos_a;
    logic [11:0] pos_b;
    logic [17:0] rd_a;
    logic [17:0] rd_b;
    logic [17:0] rd_f;
    logic        we_a;
    logic        we_b;
    logic        re_a;
    logic        re_b;
    logic [12:0] wunits;
    logic [12:0] runits;
    logic [12:0] count;
    logic        full;
    logic        empty;
    logic        wr_ok;
    logic        push;
    logic        buf_ready;

    // ------------------------------------------------------------
    // Array access helpers
    // ------------------------------------------------------------
    function automatic logic [17:0] read_at(logic [11:0] pos,
                                            dcr_width_t w);
        logic [8:0] word;
        logic [7:0] low;
        logic [7:0] mask;
        word = pos[11:3];
        low  = mem[word][7:0] >> pos[2:0];
        mask = 8'((9'h001 << dcr_units(w)) - 9'h001);
        unique case (w)
            DCR_W9:  return {9'h000, mem[word]};
            DCR_W18: return {mem[word + 9'h001], mem[word]};
            default: return {10'h000, low & mask};
        endcase
    endfunction : read_at

    task automatic put(logic [11:0] pos, dcr_width_t w, logic [17:0] d);
        logic [8:0] word;
        logic [7:0] m;
        word = pos[11:3];
        m    = 8'((9'h001 << dcr_units(w)) - 9'h001) << pos[2:0];
        unique case (w)
            DCR_W9: mem[word] <= d[8:0];
            DCR_W18: begin
                mem[word]          <= d[8:0];
                mem[word + 9'h001] <= d[17:9];
            end
            // Ninth bit left alone for narrow widths
            default: mem[word][7:0] <= (mem[word][7:0] & ~m)
                                     | ((d[7:0] << pos[2:0]) & m);
        endcase
    endtask : put

    // ------------------------------------------------------------
    // Width and address selection
    // ------------------------------------------------------------
    always_comb begin
        if (FIFO_MODE || TWO_PORT_MODE) begin
            wa = dcr_decode(WRITE_WIDTH_SELECT);
            wb = dcr_decode(READ_WIDTH_SELECT);
        end else begin
            wa = dcr_width_t'({1'b0, PORT_A_ASPECT_SELECT});
            wb = dcr_width_t'({1'b0, PORT_B_ASPECT_SELECT});
        end
    end

    // Controller pointers replace user addresses only in FIFO mode
    assign pos_a = FIFO_MODE ? st.wptr[11:0]
                             : dcr_pos(PORT_A_ADDR, wa);
    assign pos_b = dcr_pos(PORT_B_ADDR, wb);

    // Process, not assign: it must wake when the array itself changes
    always_comb begin
        rd_a = read_at(pos_a, wa);
        rd_b = read_at(pos_b, wb);
        rd_f = read_at(st.rptr[11:0], wb);
    end

    // Two-port mode: A only writes, B only reads
    assign we_a = RST_N && (FIFO_MODE ? wr_ok
                : (!PORT_A_SELECT_N && !PORT_A_WRITE_NOT_READ));
    assign re_a = !FIFO_MODE && !TWO_PORT_MODE
                && !PORT_A_SELECT_N && PORT_A_WRITE_NOT_READ;
    assign we_b = RST_N && !FIFO_MODE && !TWO_PORT_MODE
                && !PORT_B_SELECT_N && !PORT_B_WRITE_NOT_READ;
    assign re_b = !FIFO_MODE && !PORT_B_SELECT_N
                && PORT_B_WRITE_NOT_READ;

    // ------------------------------------------------------------
    // Array writes
    // ------------------------------------------------------------
    // Port B lands last, so it wins a same-address write collision
    always_ff @(posedge CLK) begin
        if (we_a) begin
            put(pos_a, wa, PORT_A_WDATA);
        end
        if (we_b) begin
            put(pos_b, wb, PORT_B_WDATA);
        end
    end

    // ------------------------------------------------------------
    // FIFO controller
    // ------------------------------------------------------------
    assign wunits = 13'(dcr_units(wa));
    assign runits = 13'(dcr_units(wb));
    assign count  = st.wptr - st.rptr;
    assign full   = (DCR_UNITS_TOTAL - count) < wunits;
    assign empty  = count < runits;
    assign wr_ok  = FIFO_MODE && FIFO_WR_VALID && !full;
    assign push   = FIFO_MODE && !empty && buf_ready;

    assign FIFO_WR_READY     = FIFO_MODE && !full;
    assign FULL              = full;
    assign EMPTY             = empty;
    assign ALMOST_FULL_FLAG  = count >= ALMOST_FULL_FLAG_LEVEL;
    assign ALMOST_EMPTY_FLAG = count <= ALMOST_EMPTY_FLAG_LEVEL;

    // Prefetch keeps the stream output fed without an extra read cycle
    dcr_stream_buf #(
        .WIDTH     (DCR_DATA_BITS),
        .DEPTH     (BUF_DEPTH)
    ) u_out_buf (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (rd_f),
        .out_valid (FIFO_RD_VALID),
        .out_ready (FIFO_RD_READY),
        .out_data  (FIFO_RD_DATA)
    );

    // ------------------------------------------------------------
    // Read pipelines and pointers
    // ------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.a_pend = re_a;
        next_st.b_pend = re_b;
        if (re_a) begin
            next_st.a_stage = rd_a;
        end
        if (re_a && !PORT_A_OUTPUT_REGISTER_SELECT) begin
            next_st.a_out = rd_a;
        end
        if (st.a_pend && PORT_A_OUTPUT_REGISTER_SELECT) begin
            next_st.a_out = st.a_stage;
        end
        if (re_b) begin
            next_st.b_stage = rd_b;
        end
        if (re_b && !PORT_B_OUTPUT_REGISTER_SELECT) begin
            next_st.b_out = rd_b;
        end
        if (st.b_pend && PORT_B_OUTPUT_REGISTER_SELECT) begin
            next_st.b_out = st.b_stage;
        end
        if (wr_ok) begin
            next_st.wptr = st.wptr + wunits;
        end
        if (push) begin
            next_st.rptr = st.rptr + runits;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= '{a_stage: DCR_DATA_RST, a_out: DCR_DATA_RST,
                    a_pend: 1'b0, b_stage: DCR_DATA_RST,
                    b_out: DCR_DATA_RST, b_pend: 1'b0,
                    wptr: DCR_PTR_RST, rptr: DCR_PTR_RST};
        end else begin
            st <= next_st;
        end
    end

    assign PORT_A_RDATA = st.a_out;
    assign PORT_B_RDATA = st.b_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_flow_read_now: assert property (@(posedge CLK)
        disable iff (!RST_N)
        re_a && !PORT_A_OUTPUT_REGISTER_SELECT
        |=> PORT_A_RDATA == $past(rd_a))
        else $error("unregistered read data late");

    a_piped_read_late: assert property (@(posedge CLK)
        disable iff (!RST_N)
        re_b && PORT_B_OUTPUT_REGISTER_SELECT
        ##1 PORT_B_OUTPUT_REGISTER_SELECT
        |=> PORT_B_RDATA == $past(rd_b, 2))
        else $error("registered read data not one cycle later");

    a_deselect_hold: assert property (@(posedge CLK)
        disable iff (!RST_N)
        PORT_A_SELECT_N && !st.a_pend |=> $stable(PORT_A_RDATA))
        else $error("deselected port output changed");

    a_write_no_out: assert property (@(posedge CLK)
        disable iff (!RST_N)
        !PORT_B_SELECT_N && !PORT_B_WRITE_NOT_READ && !st.b_pend
        |=> $stable(PORT_B_RDATA))
        else $error("write changed read output");

    a_fifo_wr_step: assert property (@(posedge CLK)
        disable iff (!RST_N)
        wr_ok |=> st.wptr == 13'($past(st.wptr) + $past(wunits)))
        else $error("write pointer step wrong");

    a_ram_ptr_idle: assert property (@(posedge CLK)
        disable iff (!RST_N)
        !FIFO_MODE |=> $stable(st.wptr) && $stable(st.rptr))
        else $error("pointer moved in RAM mode");

    a_full_blocks: assert property (@(posedge CLK)
        disable iff (!RST_N)
        FULL |-> !FIFO_WR_READY && !we_a)
        else $error("write taken while full");

    a_empty_no_pop: assert property (@(posedge CLK)
        disable iff (!RST_N)
        EMPTY |=> st.rptr == $past(st.rptr))
        else $error("read pointer moved while empty");

    a_two_port_dir: assert property (@(posedge CLK)
        disable iff (!RST_N)
        TWO_PORT_MODE |-> !we_b && !re_a)
        else $error("two-port direction broken");

    a_ninth_kept: assert property (@(posedge CLK)
        disable iff (!RST_N)
        we_a && wa < DCR_W9 && !we_b
        |=> mem[$past(pos_a[11:3])][8] == $past(mem[pos_a[11:3]][8]))
        else $error("narrow write touched ninth bit");

endmodule : dcr_block

// ===== sim/dcr_fabric_sink.sv
`timescale 1ns/1ps
module dcr_fabric_sink (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        rd_valid,
    input  wire logic [17:0] rd_data,
    input  wire logic        stall,
    input  wire logic        slow,
    output logic             rd_ready
);
    logic        phase    = 1'h0;
    logic [17:0] got [$];

    // ------------------------------------------------------------
    // Consumer side of the read stream
    // ------------------------------------------------------------
    // Ready moves off the sampling edge; slow mode stalls every other cycle
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase    <= 1'h0;
            rd_ready <= 1'h0;
        end else begin
            phase    <= ~phase;
            rd_ready <= !stall && !(slow && phase);
        end
    end

    always @(posedge clk) begin
        if (rst_n && rd_valid && rd_ready) begin
            got.push_back(rd_data);
        end
    end
endmodule : dcr_fabric_sink

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dcr_pkg::*;

    logic        clk      = 1'h0;
    logic        rst_n    = 1'h0;
    logic        fifo_mode;
    logic        two_port;
    logic [1:0]  asp   [2];
    logic [2:0]  wwid;
    logic [2:0]  rwid;
    logic        pipe  [2];
    logic        sel_n [2];
    logic        wnr   [2];
    logic [11:0] addr  [2];
    logic [17:0] wdata [2];
    logic [17:0] rd_a;
    logic [17:0] rd_b;
    logic        wr_valid;
    logic        wr_ready;
    logic        rd_valid;
    logic        rd_ready;
    logic [17:0] rd_data;
    logic        full;
    logic        empty;
    logic        almost_full_flag;
    logic        almost_empty_flag;
    logic        stall;
    logic        slow;
    logic [17:0] f;
    logic [17:0] s;
    logic [17:0] v;
    int          failures = 0;
    int          n_checks = 0;
    int          n;
    int          i;
    int          k;
    int          w;

    always #25 clk = ~clk;

    dcr_block dut_u (
        .CLK                           (clk),
        .RST_N                         (rst_n),
        .FIFO_MODE                     (fifo_mode),
        .TWO_PORT_MODE                 (two_port),
        .PORT_A_ASPECT_SELECT          (asp[0]),
        .PORT_B_ASPECT_SELECT          (asp[1]),
        .WRITE_WIDTH_SELECT            (wwid),
        .READ_WIDTH_SELECT             (rwid),
        .PORT_A_OUTPUT_REGISTER_SELECT (pipe[0]),
        .PORT_B_OUTPUT_REGISTER_SELECT (pipe[1]),
        .PORT_A_SELECT_N               (sel_n[0]),
        .PORT_B_SELECT_N               (sel_n[1]),
        .PORT_A_WRITE_NOT_READ         (wnr[0]),
        .PORT_B_WRITE_NOT_READ         (wnr[1]),
        .PORT_A_ADDR                   (addr[0]),
        .PORT_B_ADDR                   (addr[1]),
        .PORT_A_WDATA                  (wdata[0]),
        .PORT_B_WDATA                  (wdata[1]),
        .PORT_A_RDATA                  (rd_a),
        .PORT_B_RDATA                  (rd_b),
        .FIFO_WR_VALID                 (wr_valid),
        .FIFO_WR_READY                 (wr_ready),
        .FIFO_RD_VALID                 (rd_valid),
        .FIFO_RD_READY                 (rd_ready),
        .FIFO_RD_DATA                  (rd_data),
        .FULL                          (full),
        .EMPTY                         (empty),
        .ALMOST_FULL_FLAG              (almost_full_flag),
        .ALMOST_EMPTY_FLAG             (almost_empty_flag)
    );

    dcr_fabric_sink fab_u (
        .clk      (clk),
        .rst_n    (rst_n),
        .rd_valid (rd_valid),
        .rd_data  (rd_data),
        .stall    (stall),
        .slow     (slow),
        .rd_ready (rd_ready)
    );

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [17:0] seen,
                         input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One access, then a released cycle: f after edge one, s after two
    task automatic acc(input int p, input logic wr_n,
                       input logic [11:0] a, input logic [17:0] d);
        sel_n[p] = 1'h0;
        wnr[p]   = wr_n;
        addr[p]  = a;
        wdata[p] = d;
        @(negedge clk);
        f        = p ? rd_b : rd_a;
        sel_n[p] = 1'h1;
        wnr[p]   = 1'h1;
        @(negedge clk);
        s        = p ? rd_b : rd_a;
    endtask : acc

    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // Whole run is under two thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        fifo_mode = 1'h0;
        two_port  = 1'h0;
        asp[0]    = 2'h3;
        asp[1]    = 2'h3;
        wwid      = 3'h3;
        rwid      = 3'h3;
        pipe[0]   = 1'h0;
        pipe[1]   = 1'h0;
        sel_n[0]  = 1'h1;
        sel_n[1]  = 1'h1;
        wnr[0]    = 1'h1;
        wnr[1]    = 1'h1;
        addr[0]   = 12'h000;
        addr[1]   = 12'h000;
        wdata[0]  = 18'h0_0000;
        wdata[1]  = 18'h0_0000;
        wr_valid  = 1'h0;
        stall     = 1'h1;
        slow      = 1'h0;
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        check("empty_rst", empty, 18'h0_0001);
        check("almost_empty_flag_rst", almost_empty_flag, 18'h0_0001);
        check("full_rst", full, 18'h0_0000);

        acc(0, 1'h0, 12'h005, 18'h0_01A5);
        acc(1, 1'h1, 12'h005, 18'h0_0000);
        check("b_read", f, 18'h0_01A5);
        pipe[0] = 1'h1;
        acc(0, 1'h1, 12'h005, 18'h0_0000);
        check("a_pipe_first", f, 18'h0_0000);
        check("a_pipe_second", s, 18'h0_01A5);
        acc(0, 1'h0, 12'h006, 18'h0_005A);
        pipe[1] = 1'h1;
        acc(1, 1'h1, 12'h006, 18'h0_0000);
        check("b_pipe_first", f, 18'h0_01A5);
        check("b_pipe_second", s, 18'h0_005A);
        pipe[0] = 1'h0;
        pipe[1] = 1'h0;
        acc(0, 1'h1, 12'h006, 18'h0_0000);
        check("a_flow", f, 18'h0_005A);

        // Both ports write one word in the same cycle; port B wins
        sel_n[0] = 1'h0;
        sel_n[1] = 1'h0;
        wnr[0]   = 1'h0;
        wnr[1]   = 1'h0;
        addr[0]  = 12'h007;
        addr[1]  = 12'h007;
        wdata[0] = 18'h0_0111;
        wdata[1] = 18'h0_00EE;
        @(negedge clk);
        sel_n[0] = 1'h1;
        sel_n[1] = 1'h1;
        wnr[0]   = 1'h1;
        wnr[1]   = 1'h1;
        @(negedge clk);
        acc(0, 1'h1, 12'h007, 18'h0_0000);
        check("collide", f, 18'h0_00EE);

        for (k = 0; k < 3; k++) begin
            asp[1] = 2'(k);
            w      = 1 << k;
            for (i = 0; i < 8 / w; i++) begin
                acc(1, 1'h1, 12'(5 * (8 / w) + i), 18'h0_0000);
                v = 18'((8'hA5 >> (i * w)) & ((1 << w) - 1));
                check("b_narrow", f, v);
            end
        end
        v       = rd_b;
        addr[1] = 12'h000;
        @(negedge clk);
        check("b_hold", rd_b, v);

        asp[0] = 2'h2;
        asp[1] = 2'h3;
        acc(0, 1'h0, 12'h00A, 18'h0_0003);
        acc(1, 1'h1, 12'h005, 18'h0_0000);
        // Bit 8 left out: undefined after a narrow write
        check("nibble_wr", {10'h000, f[7:0]}, 18'h0_00A3);

        two_port = 1'h1;
        wwid     = 3'h4;
        v        = 18'h2_B3C6;
        acc(0, 1'h0, 12'h001, v);
        acc(1, 1'h1, 12'h002, 18'h0_0000);
        check("lo_half", f, {9'h000, v[8:0]});
        acc(1, 1'h1, 12'h003, 18'h0_0000);
        check("hi_half", f, {9'h000, v[17:9]});
        wwid = 3'h3;
        rwid = 3'h4;
        acc(0, 1'h0, 12'h008, 18'h0_0123);
        acc(0, 1'h0, 12'h009, 18'h0_0045);
        acc(1, 1'h1, 12'h004, 18'h0_0000);
        check("wide_rd", f, {9'h045, 9'h123});

        two_port  = 1'h0;
        fifo_mode = 1'h1;
        wwid      = 3'h4;
        @(negedge clk);
        n = 0;
        while (n < 400 && wr_ready === 1'h1) begin
            wdata[0] = 18'(n);
            wr_valid = 1'h1;
            @(negedge clk);
            n++;
        end
        wr_valid = 1'h0;
        check("accepted", 18'(n), 18'(DCR_WORDS / 2 + DCR_BUF_DEPTH));
        check("full", full, 18'h0_0001);
        check("almost_full_flag", almost_full_flag, 18'h0_0001);
        check("almost_empty_flag_full", almost_empty_flag, 18'h0_0000);
        stall = 1'h0;
        slow  = 1'h1;
        for (i = 0; i < 2000 && fab_u.got.size() < n; i++) begin
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
        check("popped", 18'(fab_u.got.size()), 18'(n));
        for (i = 0; i < n; i++) begin
            check("fifo_data", fab_u.got[i], 18'(i));
        end
        check("empty_end", empty, 18'h0_0001);
        check("almost_empty_flag_end", almost_empty_flag, 18'h0_0001);
        check("rd_valid_end", rd_valid, 18'h0_0000);
        give_verdict();
    end
endmodule : tb_top
